// >>> include/up_map.svh
// up_map.svh: register offsets, field positions, reset values, bit timing
// assumes inclusion by the uart design file only
`ifndef UP_MAP_SVH
`define UP_MAP_SVH
`define UP_A_DATA 3'h0
`define UP_A_IER 3'h1
`define UP_A_ISR 3'h2
`define UP_A_LCR 3'h3
`define UP_A_MCTL 3'h4
`define UP_A_LSR 3'h5
`define UP_A_MSTAT 3'h6
`define UP_A_SCR 3'h7
`define UP_LCR_STB 2
`define UP_LCR_PEN 3
`define UP_LCR_EPS 4
`define UP_LCR_STICK 5
`define UP_LCR_BRK 6
`define UP_LCR_DIVACC 7
`define UP_MC_DTR 0
`define UP_MC_RTS 1
`define UP_MC_OUT1 2
`define UP_MC_OUT2 3
`define UP_MC_LOOP 4
`define UP_IE_RX 0
`define UP_IE_THR 1
`define UP_IE_LINE 2
`define UP_IE_MODEM 3
`define UP_ISR_LINE 8'h06
`define UP_ISR_RX 8'h04
`define UP_ISR_THR 8'h02
`define UP_ISR_MODEM 8'h00
`define UP_ISR_NONE 8'h01
`define UP_SEL_CODE 3'h6
`define UP_BIT_LAST 5'h0f
`define UP_STOP15_LAST 5'h17
`define UP_STOP2_LAST 5'h1f
`define UP_RX_LAST 4'hf
`define UP_START_SAMPLE 4'h7
`define UP_FIFO_DEPTH 4
`define UP_RST_HIGH 1'b1
`endif

// >>> include/up_pkg.sv
// up_pkg.sv: state machine encodings, pin bundle and uart state record
// assumes up_map.svh is compiled alongside
package up_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
        TX_PAR = 3'b011, TX_STOP = 3'b100
    } up_txst_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
        RX_PAR = 3'b011, RX_STOP = 3'b100
    } up_rxst_t;
    typedef struct packed {
        logic rxClk, serialIn;
        logic [3:0] modemN;
        logic wrN, wrP, rdN, rdP, aln, csA, csB, csLn;
        logic [2:0] addr;
        logic [7:0] data;
    } up_pins_t;
    typedef struct packed {
        up_pins_t s1;
        up_pins_t s2;
        logic wrPrev, rdPrev, rxClkPrev, rxPrevIn;
        logic [2:0] csL, addrL;
        logic [3:0] ier;
        logic [7:0] lcr;
        logic [4:0] modem_ctrl_reg;
        logic [7:0] scr, dll, dlm, thr;
        logic thrEmpty, thrIntr, oe, pe, fe, bi;
        logic [3:0] modemPrev, delta;
        logic [15:0] bcnt;
        logic baud_16x_out;
        up_txst_t txSt;
        logic [4:0] txCnt;
        logic [2:0] txBit;
        logic [7:0] txShift;
        logic txPar, txLine, lineOut;
        up_rxst_t rxSt;
        logic [3:0] rxCnt;
        logic [2:0] rxBit;
        logic [7:0] rxShift;
        logic rxPerr, rxZero;
        logic [7:0] dataOut;
        logic dataOe, drvDisN, irq;
    } up_state_t;
endpackage

// >>> rtl/up_uart.sv
// up_uart.sv: host bus slave, baud generator, transmitter, receiver, fifo
// assumes clk is the crystal clock; every pin input is asynchronous
// Function
// - data bit 0 goes out first and is assembled first
// - line high is logic one, line low is logic zero
// - loopback cuts serial input and feeds receiver from transmitter
// - serial output stays high in reset, loopback or idle with break clear
// - each character framed by start, optional parity and stop bits
// - selected only with both high selects high and low select low
// - baud output runs at sixteen times the selected rate
// - crystal clock drives the logic and the baud generator
// - either write strobe while selected loads the addressed register
// - either read strobe while selected drives the addressed register
// - driver disable goes low during a host read
// - selected output high whenever the selects choose the device
// - address latch low captures selects and register address
// - interrupt output high on any enabled pending condition
// - modem control bit 1 drives request to send low
// - modem control bit 0 drives terminal ready low
// - user outputs follow modem control bits 2 and 3, active low
// - reset clears outputs and registers, line idles
// - clear to send readable in status bit 4, never gates transmit
// - divisor covers rates from 50 Hz to 56 kHz
// - five to eight data bits, even, odd or no parity
// - divisor access remaps addresses 0 and 1 to divisor bytes
// - loopback ties modem outputs to status inputs, interrupts live
// - start bit checked low at mid-bit after the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "up_map.svh"

module up_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk, // crystal clock
    input wire logic rst, // sync reset, high
    input wire logic inValid, // push request
    output logic inReady, // room for a word
    input wire logic [W-1:0] inData, // pushed word
    output logic outValid, // word waiting
    input wire logic outReady, // pop request
    output logic [W-1:0] outData // head word
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } up_fifo_st_t;
    up_fifo_st_t st_r, st_nxt;
    logic full, empty;
    assign empty = st_r.wp == st_r.rp;
    assign full = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && !empty;
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = st_r.mem[st_r.rp[AW-1:0]];
    always_comb begin
        st_nxt = st_r;
        if (inValid && !full) begin
            st_nxt.mem[st_r.wp[AW-1:0]] = inData;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (outReady && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // up_fifo

module up_uart import up_pkg::*; (
    input wire logic clk, // crystal clock
    input wire logic rst, // master reset, high
    input wire logic [7:0] dataIn, // host data bus in
    output logic [7:0] dataOut, // host data bus out
    output logic dataOe, // bus drive enable
    input wire logic selectHighA, // select, high
    input wire logic selectHighB, // select, high
    input wire logic selectLowN, // select, low
    input wire logic [2:0] addr, // register address
    input wire logic addressLatchN, // latch selects, low
    input wire logic writeStrobeN, // write, low
    input wire logic writeStrobeP, // write, high
    input wire logic readStrobeN, // read, low
    input wire logic readStrobeP, // read, high
    output logic driverDisableN, // low during read
    output logic selectedOut, // device selected
    output logic irqOut, // interrupt, high
    input wire logic serialIn, // serial line in
    output logic serialOut, // serial line out
    input wire logic rxClockIn, // receiver 16x clock
    output logic baud16xOut, // 16x baud clock
    input wire logic ctsN, // clear to send
    input wire logic dsrN, // data set ready
    input wire logic cdN, // carrier detect
    input wire logic riN, // ring indicator
    output logic rtsN, // request to send
    output logic dtrN, // terminal ready
    output logic userOut1N, // user output 1
    output logic userOut2N // user output 2
);
    up_state_t s_r, s_nxt;
    up_pins_t pinsNow, p;
    logic selected, wrAct, rdAct, wrStart, rdEnd, divisor_access_bit, txTick, rxTick;
    logic rxLine, txOut, bitDone, rxSample, lineInt, rxInt, thInt, msInt;
    logic pushValid, popReady, fifoValid, fifoReady;
    logic [2:0] nbits;
    logic [4:0] stopLast;
    logic [3:0] msrNow;
    logic [7:0] rxData, lsr, isr, rdVal, fifoData;
    logic [15:0] div;

    function automatic logic [7:0] charMask(input logic [2:0] nb);
        charMask = 8'hff >> (3'h7 - nb);
    endfunction
    function automatic logic parityOf(input logic [7:0] d,
                                      input logic [7:0] lc);
        if (lc[`UP_LCR_STICK]) begin
            parityOf = !lc[`UP_LCR_EPS];
        end else begin
            parityOf = lc[`UP_LCR_EPS] ? ^d : ~^d;
        end
    endfunction

    assign pinsNow = {rxClockIn, serialIn, cdN, riN, dsrN, ctsN,
                      writeStrobeN, writeStrobeP, readStrobeN, readStrobeP,
                      addressLatchN, selectHighA, selectHighB, selectLowN,
                      addr, dataIn};

    up_fifo #(.W(8), .D(`UP_FIFO_DEPTH)) rxFifo (
        .clk(clk),
        .rst(rst),
        .inValid(pushValid),
        .inReady(fifoReady),
        .inData(rxData),
        .outValid(fifoValid),
        .outReady(popReady),
        .outData(fifoData)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pinsNow;
        s_nxt.s2 = s_r.s1; // stage one feeds only stage two
        p = s_r.s2;
        pushValid = 1'b0;
        popReady = 1'b0;
        if (!p.aln) begin
            s_nxt.csL = {p.csA, p.csB, p.csLn};
            s_nxt.addrL = p.addr;
        end
        selected = s_r.csL == `UP_SEL_CODE;
        wrAct = selected && (!p.wrN || p.wrP);
        rdAct = selected && (!p.rdN || p.rdP);
        s_nxt.wrPrev = wrAct;
        s_nxt.rdPrev = rdAct;
        wrStart = wrAct && !s_r.wrPrev;
        rdEnd = !rdAct && s_r.rdPrev;
        divisor_access_bit = s_r.lcr[`UP_LCR_DIVACC];
        nbits = {1'b0, s_r.lcr[1:0]} + 3'h4;
        rxData = s_r.rxShift >> (3'h7 - nbits);
        // baud generator on the crystal clock; divisor 0 halts it
        div = {s_r.dlm, s_r.dll};
        txTick = 1'b0;
        if (div == 16'h0000) begin
            s_nxt.bcnt = 16'h0000;
        end else if (s_r.bcnt <= 16'h0001) begin
            s_nxt.bcnt = div;
            txTick = 1'b1;
        end else begin
            s_nxt.bcnt = s_r.bcnt - 16'h0001;
        end
        s_nxt.baud_16x_out = s_r.bcnt > {1'b0, div[15:1]};
        // status and interrupt priority
        msrNow = s_r.modem_ctrl_reg[`UP_MC_LOOP] ? {s_r.modem_ctrl_reg[3], s_r.modem_ctrl_reg[2],
                 s_r.modem_ctrl_reg[0], s_r.modem_ctrl_reg[1]} : ~p.modemN;
        lsr = {1'b0, s_r.thrEmpty && s_r.txSt == TX_IDLE, s_r.thrEmpty,
               s_r.bi, s_r.fe, s_r.pe, s_r.oe, fifoValid};
        lineInt = s_r.ier[`UP_IE_LINE] && (|lsr[4:1]);
        rxInt = s_r.ier[`UP_IE_RX] && fifoValid;
        thInt = s_r.ier[`UP_IE_THR] && s_r.thrIntr;
        msInt = s_r.ier[`UP_IE_MODEM] && (|s_r.delta);
        if (lineInt) begin
            isr = `UP_ISR_LINE;
        end else if (rxInt) begin
            isr = `UP_ISR_RX;
        end else if (thInt) begin
            isr = `UP_ISR_THR;
        end else if (msInt) begin
            isr = `UP_ISR_MODEM;
        end else begin
            isr = `UP_ISR_NONE;
        end
        s_nxt.irq = lineInt || rxInt || thInt || msInt;
        // read side effects first, so hardware sets below win
        if (rdEnd) begin
            if (s_r.addrL == `UP_A_DATA) begin
                popReady = !divisor_access_bit;
            end else if (s_r.addrL == `UP_A_ISR) begin
                if (isr == `UP_ISR_THR) begin
                    s_nxt.thrIntr = 1'b0;
                end
            end else if (s_r.addrL == `UP_A_LSR) begin
                s_nxt.oe = 1'b0;
                s_nxt.pe = 1'b0;
                s_nxt.fe = 1'b0;
                s_nxt.bi = 1'b0;
            end else if (s_r.addrL == `UP_A_MSTAT) begin
                s_nxt.delta = 4'h0;
            end
        end
        s_nxt.modemPrev = msrNow;
        s_nxt.delta = s_nxt.delta | (msrNow ^ s_r.modemPrev);
        // transmitter; line idles high
        stopLast = !s_r.lcr[`UP_LCR_STB] ? `UP_BIT_LAST :
                   (s_r.lcr[1:0] == 2'b00 ? `UP_STOP15_LAST : `UP_STOP2_LAST);
        bitDone = txTick && s_r.txCnt == `UP_BIT_LAST;
        if (txTick) begin
            s_nxt.txCnt = s_r.txCnt + 5'h01;
        end
        case (s_r.txSt)
            TX_IDLE: begin
                s_nxt.txCnt = 5'h00;
                s_nxt.txLine = 1'b1;
                if (!s_r.thrEmpty) begin
                    s_nxt.txSt = TX_START;
                    s_nxt.txShift = s_r.thr;
                    s_nxt.txPar = parityOf(s_r.thr & charMask(nbits), s_r.lcr);
                    s_nxt.txBit = 3'h0;
                    s_nxt.txLine = 1'b0;
                    s_nxt.thrEmpty = 1'b1;
                    s_nxt.thrIntr = 1'b1;
                end
            end
            TX_START: begin
                if (bitDone) begin
                    s_nxt.txSt = TX_DATA;
                    s_nxt.txCnt = 5'h00;
                    s_nxt.txLine = s_r.txShift[0];
                end
            end
            TX_DATA: begin
                if (bitDone) begin
                    s_nxt.txCnt = 5'h00;
                    s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
                    s_nxt.txBit = s_r.txBit + 3'h1;
                    if (s_r.txBit != nbits) begin
                        s_nxt.txLine = s_r.txShift[1];
                    end else if (s_r.lcr[`UP_LCR_PEN]) begin
                        s_nxt.txSt = TX_PAR;
                        s_nxt.txLine = s_r.txPar;
                    end else begin
                        s_nxt.txSt = TX_STOP;
                        s_nxt.txLine = 1'b1;
                    end
                end
            end
            TX_PAR: begin
                if (bitDone) begin
                    s_nxt.txSt = TX_STOP;
                    s_nxt.txCnt = 5'h00;
                    s_nxt.txLine = 1'b1;
                end
            end
            TX_STOP: begin
                if (txTick && s_r.txCnt == stopLast) begin
                    s_nxt.txSt = TX_IDLE;
                end
            end
            default: begin
                s_nxt.txSt = TX_IDLE;
            end
        endcase
        // cts is deliberately not consulted anywhere in the transmitter
        txOut = s_r.lcr[`UP_LCR_BRK] ? 1'b0 : s_r.txLine;
        s_nxt.lineOut = s_r.modem_ctrl_reg[`UP_MC_LOOP] ? 1'b1 : txOut;
        // host writes; a write into a full holding register overwrites it
        if (wrStart) begin
            if (s_r.addrL == `UP_A_DATA) begin
                if (divisor_access_bit) begin
                    s_nxt.dll = p.data;
                end else begin
                    s_nxt.thr = p.data;
                    s_nxt.thrEmpty = 1'b0;
                    s_nxt.thrIntr = 1'b0;
                end
            end else if (s_r.addrL == `UP_A_IER) begin
                if (divisor_access_bit) begin
                    s_nxt.dlm = p.data;
                end else begin
                    s_nxt.ier = p.data[3:0];
                end
            end else if (s_r.addrL == `UP_A_LCR) begin
                s_nxt.lcr = p.data;
            end else if (s_r.addrL == `UP_A_MCTL) begin
                s_nxt.modem_ctrl_reg = p.data[4:0];
            end else if (s_r.addrL == `UP_A_SCR) begin
                s_nxt.scr = p.data;
            end
        end
        // receiver on the synchronised rx clock edge
        rxLine = s_r.modem_ctrl_reg[`UP_MC_LOOP] ? txOut : p.serialIn;
        rxTick = s_r.s2.rxClk && !s_r.rxClkPrev;
        s_nxt.rxClkPrev = s_r.s2.rxClk;
        s_nxt.rxPrevIn = rxLine;
        rxSample = rxTick && s_r.rxCnt == `UP_RX_LAST;
        if (rxTick) begin
            s_nxt.rxCnt = s_r.rxCnt + 4'h1;
        end
        case (s_r.rxSt)
            RX_IDLE: begin
                s_nxt.rxCnt = 4'h0;
                if (s_r.rxPrevIn && !rxLine) begin
                    s_nxt.rxSt = RX_START;
                end
            end
            RX_START: begin
                if (rxTick && s_r.rxCnt == `UP_START_SAMPLE) begin
                    s_nxt.rxCnt = 4'h0;
                    s_nxt.rxBit = 3'h0;
                    s_nxt.rxZero = 1'b1;
                    s_nxt.rxPerr = 1'b0;
                    s_nxt.rxSt = rxLine ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxSample) begin
                    s_nxt.rxShift = {rxLine, s_r.rxShift[7:1]};
                    s_nxt.rxBit = s_r.rxBit + 3'h1;
                    s_nxt.rxZero = s_r.rxZero && !rxLine;
                    if (s_r.rxBit == nbits) begin
                        s_nxt.rxSt = s_r.lcr[`UP_LCR_PEN] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rxSample) begin
                    s_nxt.rxPerr = rxLine != parityOf(rxData, s_r.lcr);
                    s_nxt.rxZero = s_r.rxZero && !rxLine;
                    s_nxt.rxSt = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rxSample) begin
                    s_nxt.rxSt = RX_IDLE;
                    pushValid = 1'b1;
                    s_nxt.oe = s_nxt.oe || !fifoReady;
                    s_nxt.pe = s_nxt.pe || s_r.rxPerr;
                    s_nxt.fe = s_nxt.fe || !rxLine;
                    s_nxt.bi = s_nxt.bi || (s_r.rxZero && !rxLine);
                end
            end
            default: begin
                s_nxt.rxSt = RX_IDLE;
            end
        endcase
        // read data is registered; bus enable follows the strobe
        if (s_r.addrL == `UP_A_DATA) begin
            rdVal = divisor_access_bit ? s_r.dll : fifoData;
        end else if (s_r.addrL == `UP_A_IER) begin
            rdVal = divisor_access_bit ? s_r.dlm : {4'h0, s_r.ier};
        end else if (s_r.addrL == `UP_A_ISR) begin
            rdVal = isr;
        end else if (s_r.addrL == `UP_A_LCR) begin
            rdVal = s_r.lcr;
        end else if (s_r.addrL == `UP_A_MCTL) begin
            rdVal = {3'h0, s_r.modem_ctrl_reg};
        end else if (s_r.addrL == `UP_A_LSR) begin
            rdVal = lsr;
        end else if (s_r.addrL == `UP_A_MSTAT) begin
            rdVal = {s_r.modemPrev, s_r.delta};
        end else begin
            rdVal = s_r.scr;
        end
        s_nxt.dataOut = rdVal;
        s_nxt.dataOe = rdAct;
        s_nxt.drvDisN = !rdAct;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.lineOut <= `UP_RST_HIGH;
            s_r.txLine <= `UP_RST_HIGH;
            s_r.thrEmpty <= `UP_RST_HIGH;
            s_r.thrIntr <= `UP_RST_HIGH;
            s_r.drvDisN <= `UP_RST_HIGH;
            // modem bits of the sync stages rest at the idle pin level: no false modem delta
            s_r.s1.modemN <= {4{`UP_RST_HIGH}};
            s_r.s2.modemN <= {4{`UP_RST_HIGH}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dataOut = s_r.dataOut;
    assign dataOe = s_r.dataOe;
    assign driverDisableN = s_r.drvDisN;
    assign selectedOut = selected;
    assign irqOut = s_r.irq;
    assign serialOut = s_r.lineOut;
    assign baud16xOut = s_r.baud_16x_out;
    assign rtsN = !s_r.modem_ctrl_reg[`UP_MC_RTS];
    assign dtrN = !s_r.modem_ctrl_reg[`UP_MC_DTR];
    assign userOut1N = !s_r.modem_ctrl_reg[`UP_MC_OUT1];
    assign userOut2N = !s_r.modem_ctrl_reg[`UP_MC_OUT2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sTxReady;
        s_r.txSt == TX_IDLE && !s_r.thrEmpty;
    endsequence
    sequence sTxLoaded;
        s_r.txSt == TX_START && s_r.thrEmpty;
    endsequence
    a_tx_load: assert property (sTxReady |=> sTxLoaded)
        else $error("holding register not loaded into transmitter");
    a_start_low: assert property (s_r.txSt == TX_START &&
        !s_r.lcr[`UP_LCR_BRK] && !s_r.modem_ctrl_reg[`UP_MC_LOOP] |=> !serialOut)
        else $error("start bit not low");
    a_loop_mark: assert property (s_r.modem_ctrl_reg[`UP_MC_LOOP] |=> serialOut)
        else $error("serial out not mark in loopback");
    a_loop_modem: assert property (s_r.modem_ctrl_reg[`UP_MC_LOOP] &&
        s_r.modem_ctrl_reg[`UP_MC_RTS] |=> s_r.modemPrev[0])
        else $error("loopback status does not follow control");
    a_cts_status: assert property (!s_r.modem_ctrl_reg[`UP_MC_LOOP] &&
        !s_r.s2.modemN[0] |=> s_r.modemPrev[0])
        else $error("cts not visible in status bit 4");
    a_select_echo: assert property (!s_r.s2.aln && s_r.s2.csA &&
        s_r.s2.csB && !s_r.s2.csLn |=> selectedOut)
        else $error("selected output missing");
    a_read_driver_disable_n: assert property (rdAct |=> !driverDisableN && dataOe)
        else $error("driver disable not low during read");
    a_irq_rx: assert property (s_r.ier[`UP_IE_RX] && fifoValid |=> irqOut)
        else $error("receive interrupt missing");
    a_baud_load: assert property (txTick |=> s_r.bcnt == $past(div))
        else $error("baud counter not reloaded");
    a_rts_write: assert property (wrStart && s_r.addrL == `UP_A_MCTL
        |=> rtsN == !$past(s_r.s2.data[1]))
        else $error("request to send does not follow write");
endmodule // up_uart
`default_nettype wire

// >>> verification/up_modem_model.sv
// up_modem_model.sv: serial line and modem status lines behind the uart
// assumes the bench changes loopOn and lineOn only between characters
`timescale 1ns/1ns
`default_nettype none
module up_modem_model (
    input wire logic txLine, // uart serial output
    input wire logic loopOn, // echo line back
    input wire logic [3:0] lineOn, // cd ri dsr cts asserted
    output logic rxLine, // uart serial input
    output logic [3:0] modemN // cd ri dsr cts pins
);
    // unplugged line rests at mark, as a pulled-up receiver sees it
    assign rxLine = loopOn ? txLine : 1'b1;
    assign modemN = ~lineOn;
endmodule // up_modem_model
`default_nettype wire

// >>> verification/up_uart_bench.sv
// up_uart_bench.sv: pin-level register, select and serial tests
// assumes up_modem_model as the far side; rx clock fed from baud output
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, sn) begin comparisons++; if ((ex) !== (sn)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, sn); end end
module up_uart_bench import up_pkg::*;;
    logic clk = 0, rst = 1, csA = 1, csB = 1, csLn = 0, aln = 0;
    logic wrN = 1, wrP = 0, rdN = 1, rdP = 0, rxClk = 0, loopOn = 0;
    logic [7:0] din = 0, dout;
    logic [2:0] addr = 0;
    logic [3:0] lineOn = 0, modemN;
    logic oe, ddisN, selO, irq, serial_in, serial_out, b16, rtsN, dtrN, u1N, u2N, b16Prev;
    // 8-bit formats: none, odd, even, forced-one parity, then two stop bits
    logic [7:0] fmt [5] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h07};
    int err_count = 0, comparisons = 0, r;
    up_uart up_uart_inst (.clk(clk), .rst(rst), .dataIn(din),
        .dataOut(dout), .dataOe(oe), .selectHighA(csA), .selectHighB(csB),
        .selectLowN(csLn), .addr(addr), .addressLatchN(aln),
        .writeStrobeN(wrN), .writeStrobeP(wrP), .readStrobeN(rdN),
        .readStrobeP(rdP), .driverDisableN(ddisN), .selectedOut(selO),
        .irqOut(irq), .serialIn(serial_in), .serialOut(serial_out), .rxClockIn(rxClk),
        .baud16xOut(b16), .ctsN(modemN[0]), .dsrN(modemN[1]),
        .cdN(modemN[3]), .riN(modemN[2]), .rtsN(rtsN), .dtrN(dtrN),
        .userOut1N(u1N), .userOut2N(u2N));
    up_modem_model up_modem_model_inst (.txLine(serial_out), .loopOn(loopOn),
        .lineOn(lineOn), .rxLine(serial_in), .modemN(modemN));
    initial forever #25 clk = ~clk;
    always @(posedge clk) rxClk <= b16;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d,
        input logic p = 0);
        addr <= a;
        din <= d;
        tick(2);
        // data settles before the strobe; sync lag is two clocks
        if (p) wrP <= 1'b1; else wrN <= 1'b0;
        tick(4);
        wrP <= 1'b0;
        wrN <= 1'b1;
        tick(3);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e,
        input logic p = 0, input logic [7:0] m = 8'hff);
        addr <= a;
        tick(2);
        if (p) rdP <= 1'b1; else rdN <= 1'b0;
        tick(6);
        `CHK("drive disable", 2'b01, {ddisN, oe})
        `CHK("read data", e, dout & m)
        rdP <= 1'b0;
        rdN <= 1'b1;
        tick(6);
    endtask
    task automatic xfer(input logic [7:0] d, input logic lp);
        int n, lows;
        n = 0;
        lows = 0;
        wr(3'h0, d);
        while (irq !== 1'b1 && n < 4000) begin
            tick(1);
            n++;
            if (serial_out === 1'b0) lows++;
        end
        `CHK("irq raised", 1'b1, irq)
        `CHK("line quiet", lp, lows == 0)
        if (n >= 4000) wrap_up();
        rd(3'h0, d);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    task automatic wrap_up();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        tick(8);
        `CHK("reset", 7'h7e, {serial_out, rtsN, dtrN, u1N, u2N, ddisN, oe})
        rst <= 1'b0;
        tick(3);
        for (int i = 0; i < 8; i++) begin
            {csA, csB, csLn} <= i[2:0];
            tick(5);
            `CHK("selected", i == 6, selO)
        end
        csLn <= 1'b0;
        tick(5);
        aln <= 1'b1;
        tick(3);
        csA <= 1'b0;
        tick(5);
        `CHK("latched select", 1'b1, selO)
        aln <= 1'b0;
        csA <= 1'b1;
        wr(3'h4, 8'h0f);
        `CHK("modem", 4'h0, {rtsN, dtrN, u1N, u2N})
        wr(3'h4, 8'h05);
        `CHK("modem", 4'h9, {rtsN, dtrN, u1N, u2N})
        wr(3'h7, 8'h5a, 1'b1);
        csA <= 1'b0;
        wr(3'h7, 8'h33);
        csA <= 1'b1;
        rd(3'h7, 8'h5a, 1'b1);
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h04);
        wr(3'h1, 8'h00);
        rd(3'h0, 8'h04);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h01);
        rd(3'h1, 8'h01);
        r = 0;
        @(negedge clk);
        b16Prev = b16;
        repeat (40) begin
            @(negedge clk); // sample away from the launching edge
            if (b16 === 1'b1 && b16Prev === 1'b0) r++;
            b16Prev = b16;
        end
        tick(1);
        `CHK("baud edges", 10, r)
        loopOn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(3'h3, fmt[i]);
            xfer(8'ha5 ^ i[7:0], 1'b0);
        end
        loopOn <= 1'b0;
        wr(3'h4, 8'h12);
        rd(3'h6, 8'h10, 1'b0, 8'hf0);
        xfer(8'h3c, 1'b1);
        tick(100); // stop bits still leave the shifter after the rx push
        rd(3'h5, 8'h60);
        wr(3'h4, 8'h00);
        lineOn <= 4'h1;
        tick(4);
        rd(3'h6, 8'h10, 1'b0, 8'hf0);
        wrap_up();
    end
endmodule // up_uart_bench
`undef CHK
`default_nettype wire
